// ---- core/urd_pkg.sv ----
// Shared constants, states and carrier types of the serial port register datapath
package urd_pkg;
   // Register offsets (byte addresses)
   localparam logic [6:0] OFF_DATA   = 7'h00;
   localparam logic [6:0] OFF_IER    = 7'h04;
   localparam logic [6:0] OFF_IIR    = 7'h08;
   localparam logic [6:0] OFF_LCR    = 7'h0C;
   localparam logic [6:0] OFF_LSR    = 7'h14;
   localparam logic [6:0] OFF_SCR    = 7'h1C;
   localparam logic [6:0] OFF_ACR    = 7'h20;
   localparam logic [6:0] OFF_FDR    = 7'h28;
   localparam logic [6:0] OFF_TER    = 7'h30;
   localparam logic [6:0] OFF_MDCTL  = 7'h4C;
   localparam logic [6:0] OFF_MDADR  = 7'h50;
   // Line control fields
   localparam int LCR_WLS_LSB  = 0;
   localparam int LCR_STOP_BIT = 2;
   localparam int LCR_PEN_BIT  = 3;
   localparam int LCR_PSEL_LSB = 4;
   localparam int LCR_BRK_BIT  = 6;
   localparam int LCR_DIVSEL_BIT = 7;
   // FIFO control fields
   localparam int FCR_EN_BIT    = 0;
   localparam int FCR_RXCLR_BIT = 1;
   localparam int FCR_TXCLR_BIT = 2;
   localparam int FCR_TRIG_LSB  = 6;
   // Multidrop control fields
   localparam int MD_EN_BIT    = 0;
   localparam int MD_RXDIS_BIT = 1;
   localparam int MD_AAD_BIT   = 2;
   localparam int MD_DIR_BIT   = 4;
   localparam int MD_INV_BIT   = 5;
   // Transmit enable field
   localparam int TER_EN_BIT   = 7;
   // Interrupt enable fields
   localparam int IER_RDA_BIT  = 0;
   localparam int IER_THRE_BIT = 1;
   localparam int IER_RLS_BIT  = 2;
   // Writable bit masks
   localparam logic [9:0] IER_WMASK = 10'h307;
   localparam logic [9:0] ACR_WMASK = 10'h307;
   localparam logic [5:0] MD_WMASK  = 6'h37;
   // Reset values
   localparam logic [7:0] RST_DLL = 8'h01;
   localparam logic [7:0] RST_DLM = 8'h00;
   localparam logic [7:0] RST_LCR = 8'h00;
   localparam logic [7:0] RST_FDR = 8'h10;
   localparam logic [7:0] RST_TER = 8'h80;
   // Interrupt identification codes (bits 3:1)
   localparam logic [2:0] IIR_RLS  = 3'h3;
   localparam logic [2:0] IIR_RDA  = 3'h2;
   localparam logic [2:0] IIR_THRE = 3'h1;
   // Receive trigger levels
   localparam logic [4:0] TRIG_L0 = 5'h01;
   localparam logic [4:0] TRIG_L1 = 5'h04;
   localparam logic [4:0] TRIG_L2 = 5'h08;
   localparam logic [4:0] TRIG_L3 = 5'h0E;
   // FIFO depth in entries; timing in baud ticks
   localparam int FIFO_DEPTH = 16;
   localparam logic [3:0] TICK_MID  = 4'h7;
   localparam logic [3:0] TICK_LAST = 4'hF;

   typedef enum logic [2:0] {
      URD_IDLE  = 3'b000,
      URD_START = 3'b001,
      URD_DATA  = 3'b011,
      URD_PAR   = 3'b010,
      URD_STOP  = 3'b110
   } urd_state_t;

   typedef struct packed {
      logic       brk;
      logic       frm;
      logic       par;
      logic [7:0] data;
   } urd_rx_entry_t;
endpackage : urd_pkg

// ---- core/urd_fifo.sv ----
// Flip-flop FIFO with head output and fill count
`timescale 1ns/1ps
module urd_fifo
   import urd_pkg::*;
#(
   parameter int W     = 8,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                       clk_in,
   input  wire logic                       rstn_in,
   input  wire logic                       ce_in,
   input  wire logic                       clr_in,
   // Fill side
   input  wire logic                       push_in,
   input  wire logic [W-1:0]               data_in,
   // Drain side
   input  wire logic                       pop_in,
   output logic      [W-1:0]               head_out,
   output logic      [$clog2(DEPTH):0]     count_out,
   output logic                            full_out,
   output logic                            empty_out
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          do_push;
   logic          do_pop;

   assign full_out  = (cnt_r == (AW+1)'(DEPTH));
   assign empty_out = (cnt_r == '0);
   assign do_push   = push_in & ~full_out;
   assign do_pop    = pop_in & ~empty_out;
   assign head_out  = mem_r[rp_r];
   assign count_out = cnt_r;

   always_ff @(posedge clk_in) begin
      if (!rstn_in || (ce_in && clr_in)) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else if (ce_in) begin
         if (do_push) begin
            mem_r[wp_r] <= data_in;
            wp_r        <= wp_r + 1'b1;
         end
         if (do_pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule : urd_fifo

// ---- core/urd_baud.sv ----
// Fractional pre-divider and 16-bit divisor producing the 16x baud tick
`timescale 1ns/1ps
module urd_baud
   import urd_pkg::*;
#(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             ce_in,
   // Settings
   input  wire logic [DIV_W-1:0] div_in,
   input  wire logic [3:0]       mulval_in,
   input  wire logic [3:0]       divadd_in,
   // Tick at 16x the bit rate
   output logic                  tick_out
);
   logic [4:0]       owe_r;
   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] div_eff;
   logic [4:0]       mul_eff;
   logic             stall;

   // Zero divisor divides by one; zero multiplier treated as one
   assign div_eff = (div_in == '0) ? DIV_W'(1) : div_in;
   assign mul_eff = (mulval_in == 4'h0) ? 5'h01 : {1'b0, mulval_in};
   // Stall cycles give a rate of mul/(mul+divadd)
   assign stall   = (owe_r >= mul_eff);

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         owe_r    <= '0;
         cnt_r    <= '0;
         tick_out <= 1'b0;
      end else if (ce_in) begin
         tick_out <= 1'b0;
         if (stall) begin
            owe_r <= owe_r - mul_eff;
         end else begin
            owe_r <= owe_r + {1'b0, divadd_in};
            if (cnt_r >= div_eff - 1'b1) begin
               cnt_r    <= '0;
               tick_out <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end
endmodule : urd_baud

// ---- core/urd_top.sv ----
// Serial port register map, receiver and transmitter
// Operation
// - Line control bit 7 selects divisor latches at the shared offsets.
// - Bank zero: offset zero reads receive FIFO head, writes push transmit FIFO.
// - Bank one: offsets zero/four are divisor low/high; bank zero: four is enables.
// - Offset eight reads interrupt identity (reset 0x01), writes FIFO control.
// - Interrupt enable register holds separate enables for the interrupt sources.
// - Receive and transmit FIFOs each hold sixteen bytes.
// - Receive data-available threshold selectable at 1, 4, 8 or 14 bytes.
// - Bit 0 is first received bit; unused upper bits read zero.
// - Parity, framing and break status describe the receive FIFO head byte.
// - Written bytes queue and leave LSB first once transmitter is free.
// - Divisor with fractional divider yields a 16x bit-rate baud tick.
// - A zero divisor divides as one.
// - Fractional divider feeds the baud divider and resets to 0x10.
// - Line control holds frame format and break control, resets to zero.
// - Transmit enable can halt the transmitter; resets to 0x80.
// - Scratch register is an eight-bit store with no side effect.
// - Line status reports receive/transmit status and errors, resets 0x60.
// - Auto-baud control register holds the auto-baud controls.
// - Nine-bit multidrop mode with transmit direction output, own control register.
// - Multidrop received addresses compare with address-match register, reset zero.
// - Receive on the receive input, transmit on the transmit output.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module urd_top
   import urd_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        ce_in,
   // Register port
   input  wire logic [6:0]  addr_in,
   input  wire logic [31:0] wr_data_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rd_data_out,
   // Serial line
   input  wire logic        rxd_in,
   output logic             txd_out,
   output logic             tx_dir_out
);
   // Word-length mask: 5..8 bits
   function automatic logic [7:0] wl_mask(input logic [1:0] wls);
      wl_mask = 8'hFF >> (2'h3 - wls);
   endfunction : wl_mask

   // Parity bit value for a character under the given select
   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] sel);
      unique case (sel)
         2'h0: par_bit = ~^d;
         2'h1: par_bit = ^d;
         2'h2: par_bit = 1'b1;
         2'h3: par_bit = 1'b0;
      endcase
   endfunction : par_bit

   // Registers
   logic [7:0]  lcr_r;
   logic [7:0]  dll_r;
   logic [7:0]  dlm_r;
   logic [9:0]  ier_r;
   logic        fen_r;
   logic [1:0]  trig_r;
   logic [7:0]  scr_r;
   logic [9:0]  acr_r;
   logic [7:0]  fdr_r;
   logic [7:0]  ter_r;
   logic [5:0]  md_ctl_r;
   logic [7:0]  md_adr_r;
   logic        ovr_r;
   logic        rx_on_r;

   // Decode
   logic        divsel;
   logic        wr_dat;
   logic        wr_dll;
   logic        wr_dlm;
   logic        wr_ier;
   logic        wr_fcr;
   logic        rd_rbr;
   logic        rd_lsr;
   logic [31:0] rd_mux;

   // FIFO wiring
   urd_rx_entry_t rx_entry_r;
   urd_rx_entry_t rx_head;
   logic          rx_push_r;
   logic [4:0]    rx_cnt;
   logic          rx_full;
   logic          rx_empty;
   logic [7:0]    tx_head;
   logic          tx_empty;
   logic          tx_pop;
   logic          rx_clr;
   logic          tx_clr;

   // Baud tick
   logic          tick;

   // Receiver
   urd_state_t    rx_st_r;
   logic [3:0]    rx_tc_r;
   logic [2:0]    rx_bit_r;
   logic [7:0]    rx_sh_r;
   logic          rx_par_r;
   logic          rx_is_addr;
   logic          rx_keep;
   logic          rx_perr;

   // Transmitter
   urd_state_t    tx_st_r;
   logic [3:0]    tx_tc_r;
   logic [2:0]    tx_bit_r;
   logic [7:0]    tx_sh_r;
   logic          tx_par_r;
   logic          tx_line_r;
   logic          tx_stop2_r;

   // Status
   logic [4:0]    trig_lvl;
   logic          head_err;
   logic [7:0]    lsr;
   logic          int_rls;
   logic          int_rda;
   logic          int_thre;
   logic [7:0]    iir;

   assign divsel = lcr_r[LCR_DIVSEL_BIT];
   assign wr_dat = wr_in & (addr_in == OFF_DATA) & ~divsel;
   assign wr_dll = wr_in & (addr_in == OFF_DATA) & divsel;
   assign wr_dlm = wr_in & (addr_in == OFF_IER) & divsel;
   assign wr_ier = wr_in & (addr_in == OFF_IER) & ~divsel;
   assign wr_fcr = wr_in & (addr_in == OFF_IIR);
   assign rd_rbr = rd_in & (addr_in == OFF_DATA) & ~divsel;
   assign rd_lsr = rd_in & (addr_in == OFF_LSR);
   assign rx_clr = wr_fcr & wr_data_in[FCR_RXCLR_BIT];
   assign tx_clr = wr_fcr & wr_data_in[FCR_TXCLR_BIT];

   urd_fifo #(.W($bits(urd_rx_entry_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_in    (clk_in),
      .rstn_in   (rstn_in),
      .ce_in     (ce_in),
      .clr_in    (rx_clr),
      .push_in   (rx_push_r),
      .data_in   (rx_entry_r),
      .pop_in    (rd_rbr),
      .head_out  (rx_head),
      .count_out (rx_cnt),
      .full_out  (rx_full),
      .empty_out (rx_empty)
   );

   urd_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk_in    (clk_in),
      .rstn_in   (rstn_in),
      .ce_in     (ce_in),
      .clr_in    (tx_clr),
      .push_in   (wr_dat),
      .data_in   (wr_data_in[7:0]),
      .pop_in    (tx_pop),
      .head_out  (tx_head),
      .count_out (),
      .full_out  (),
      .empty_out (tx_empty)
   );

   urd_baud #(.DIV_W(16)) u_baud (
      .clk_in    (clk_in),
      .rstn_in   (rstn_in),
      .ce_in     (ce_in),
      .div_in    ({dlm_r, dll_r}),
      .mulval_in (fdr_r[7:4]),
      .divadd_in (fdr_r[3:0]),
      .tick_out  (tick)
   );

   // Status and identification
   assign trig_lvl = (trig_r == 2'h0) ? TRIG_L0 :
                     (trig_r == 2'h1) ? TRIG_L1 :
                     (trig_r == 2'h2) ? TRIG_L2 : TRIG_L3;
   assign head_err = ~rx_empty & (rx_head.par | rx_head.frm | rx_head.brk);
   assign lsr      = {head_err, tx_empty & (tx_st_r == URD_IDLE), tx_empty,
                      ~rx_empty & rx_head.brk, ~rx_empty & rx_head.frm,
                      ~rx_empty & rx_head.par, ovr_r, ~rx_empty};
   assign int_rls  = ier_r[IER_RLS_BIT] & (ovr_r | head_err);
   assign int_rda  = ier_r[IER_RDA_BIT] & (rx_cnt >= trig_lvl);
   assign int_thre = ier_r[IER_THRE_BIT] & tx_empty;
   assign iir      = {{2{fen_r}}, 2'h0,
                      int_rls ? IIR_RLS : int_rda ? IIR_RDA : int_thre ? IIR_THRE : 3'h0,
                      ~(int_rls | int_rda | int_thre)};

   // Read selection
   assign rd_mux = (addr_in == OFF_DATA)  ? {24'h0, divsel ? dll_r : rx_head.data} :
                   (addr_in == OFF_IER)   ? (divsel ? {24'h0, dlm_r} : {22'h0, ier_r}) :
                   (addr_in == OFF_IIR)   ? {24'h0, iir} :
                   (addr_in == OFF_LCR)   ? {24'h0, lcr_r} :
                   (addr_in == OFF_LSR)   ? {24'h0, lsr} :
                   (addr_in == OFF_SCR)   ? {24'h0, scr_r} :
                   (addr_in == OFF_ACR)   ? {22'h0, acr_r} :
                   (addr_in == OFF_FDR)   ? {24'h0, fdr_r} :
                   (addr_in == OFF_TER)   ? {24'h0, ter_r} :
                   (addr_in == OFF_MDCTL) ? {26'h0, md_ctl_r} :
                   (addr_in == OFF_MDADR) ? {24'h0, md_adr_r} : 32'h0;

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rd_data_out <= 32'h0;
      end else if (ce_in) begin
         rd_data_out <= rd_in ? rd_mux : 32'h0;
      end
   end

   // Software-written registers
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         lcr_r    <= RST_LCR;
         dll_r    <= RST_DLL;
         dlm_r    <= RST_DLM;
         ier_r    <= '0;
         fen_r    <= 1'b0;
         trig_r   <= 2'h0;
         scr_r    <= 8'h00;
         acr_r    <= '0;
         fdr_r    <= RST_FDR;
         ter_r    <= RST_TER;
         md_ctl_r <= '0;
         md_adr_r <= 8'h00;
      end else if (ce_in && wr_in) begin
         if (addr_in == OFF_LCR)   lcr_r <= wr_data_in[7:0];
         if (wr_dll)               dll_r <= wr_data_in[7:0];
         if (wr_dlm)               dlm_r <= wr_data_in[7:0];
         if (wr_ier)               ier_r <= wr_data_in[9:0] & IER_WMASK;
         if (wr_fcr) begin
            fen_r  <= wr_data_in[FCR_EN_BIT];
            trig_r <= wr_data_in[FCR_TRIG_LSB +: 2];
         end
         if (addr_in == OFF_SCR)   scr_r <= wr_data_in[7:0];
         if (addr_in == OFF_ACR)   acr_r <= wr_data_in[9:0] & ACR_WMASK;
         if (addr_in == OFF_FDR)   fdr_r <= wr_data_in[7:0];
         if (addr_in == OFF_TER)   ter_r <= {wr_data_in[TER_EN_BIT], 7'h00};
         if (addr_in == OFF_MDCTL) md_ctl_r <= wr_data_in[5:0] & MD_WMASK;
         if (addr_in == OFF_MDADR) md_adr_r <= wr_data_in[7:0];
      end
   end

   // Overrun is sticky; a new overrun beats the clear by a status read
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ovr_r <= 1'b0;
      end else if (ce_in) begin
         ovr_r <= (ovr_r & ~rd_lsr) | (rx_push_r & rx_full);
      end
   end

   // Receiver acceptance in multidrop mode
   assign rx_is_addr = md_ctl_r[MD_EN_BIT] & rx_par_r;
   assign rx_keep    = ~md_ctl_r[MD_EN_BIT] |
                       (md_ctl_r[MD_AAD_BIT] ? (~rx_is_addr & rx_on_r)
                                             : ~md_ctl_r[MD_RXDIS_BIT]);
   assign rx_perr    = lcr_r[LCR_PEN_BIT] & ~md_ctl_r[MD_EN_BIT] &
                       (rx_par_r != par_bit(rx_sh_r, lcr_r[LCR_PSEL_LSB +: 2]));

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rx_st_r    <= URD_IDLE;
         rx_tc_r    <= 4'h0;
         rx_bit_r   <= 3'h0;
         rx_sh_r    <= 8'h00;
         rx_par_r   <= 1'b0;
         rx_push_r  <= 1'b0;
         rx_entry_r <= '0;
         rx_on_r    <= 1'b0;
      end else if (ce_in) begin
         rx_push_r <= 1'b0;
         if (tick) begin
            rx_tc_r <= rx_tc_r + 1'b1;
            unique case (rx_st_r)
               URD_IDLE: begin
                  rx_tc_r <= 4'h0;
                  if (!rxd_in) rx_st_r <= URD_START;
               end
               URD_START: begin
                  if (rx_tc_r == TICK_MID) begin
                     rx_tc_r  <= 4'h0;
                     rx_bit_r <= 3'h0;
                     rx_sh_r  <= 8'h00;
                     rx_par_r <= 1'b0;
                     rx_st_r  <= rxd_in ? URD_IDLE : URD_DATA;
                  end
               end
               URD_DATA: begin
                  if (rx_tc_r == TICK_LAST) begin
                     rx_sh_r[rx_bit_r] <= rxd_in;
                     rx_bit_r          <= rx_bit_r + 1'b1;
                     if (rx_bit_r == {1'b1, lcr_r[LCR_WLS_LSB +: 2]})
                        rx_st_r <= lcr_r[LCR_PEN_BIT] ? URD_PAR : URD_STOP;
                  end
               end
               URD_PAR: begin
                  if (rx_tc_r == TICK_LAST) begin
                     rx_par_r <= rxd_in;
                     rx_st_r  <= URD_STOP;
                  end
               end
               URD_STOP: begin
                  if (rx_tc_r == TICK_LAST) begin
                     rx_st_r          <= URD_IDLE;
                     rx_entry_r.data  <= rx_sh_r;
                     rx_entry_r.par   <= rx_perr;
                     rx_entry_r.frm   <= ~rxd_in;
                     rx_entry_r.brk   <= ~rxd_in & ~rx_par_r & (rx_sh_r == 8'h00);
                     rx_push_r        <= rx_keep;
                     if (rx_is_addr && md_ctl_r[MD_AAD_BIT])
                        rx_on_r <= (rx_sh_r == md_adr_r);
                  end
               end
               default: rx_st_r <= URD_IDLE;
            endcase
         end
      end
   end

   // Transmitter: start only when enabled and a byte is waiting
   assign tx_pop = ce_in & tick & (tx_st_r == URD_IDLE) & ter_r[TER_EN_BIT] & ~tx_empty;

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         tx_st_r    <= URD_IDLE;
         tx_tc_r    <= 4'h0;
         tx_bit_r   <= 3'h0;
         tx_sh_r    <= 8'h00;
         tx_par_r   <= 1'b0;
         tx_line_r  <= 1'b1;
         tx_stop2_r <= 1'b0;
      end else if (ce_in && tick) begin
         tx_tc_r <= tx_tc_r + 1'b1;
         unique case (tx_st_r)
            URD_IDLE: begin
               tx_tc_r   <= 4'h0;
               tx_line_r <= 1'b1;
               if (tx_pop) begin
                  tx_sh_r   <= tx_head & wl_mask(lcr_r[LCR_WLS_LSB +: 2]);
                  tx_par_r  <= par_bit(tx_head & wl_mask(lcr_r[LCR_WLS_LSB +: 2]),
                                       lcr_r[LCR_PSEL_LSB +: 2]);
                  tx_line_r <= 1'b0;
                  tx_st_r   <= URD_START;
               end
            end
            URD_START: begin
               if (tx_tc_r == TICK_LAST) begin
                  tx_line_r <= tx_sh_r[0];
                  tx_bit_r  <= 3'h0;
                  tx_st_r   <= URD_DATA;
               end
            end
            URD_DATA: begin
               if (tx_tc_r == TICK_LAST) begin
                  tx_sh_r  <= tx_sh_r >> 1;
                  tx_bit_r <= tx_bit_r + 1'b1;
                  if (tx_bit_r == {1'b1, lcr_r[LCR_WLS_LSB +: 2]}) begin
                     tx_line_r  <= lcr_r[LCR_PEN_BIT] ? tx_par_r : 1'b1;
                     tx_stop2_r <= lcr_r[LCR_STOP_BIT];
                     tx_st_r    <= lcr_r[LCR_PEN_BIT] ? URD_PAR : URD_STOP;
                  end else begin
                     tx_line_r <= tx_sh_r[1];
                  end
               end
            end
            URD_PAR: begin
               if (tx_tc_r == TICK_LAST) begin
                  tx_line_r <= 1'b1;
                  tx_st_r   <= URD_STOP;
               end
            end
            URD_STOP: begin
               if (tx_tc_r == TICK_LAST) begin
                  tx_stop2_r <= 1'b0;
                  if (!tx_stop2_r) tx_st_r <= URD_IDLE;
               end
            end
            default: tx_st_r <= URD_IDLE;
         endcase
      end
   end

   // Line outputs: break forces the line low; direction follows activity
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         txd_out    <= 1'b1;
         tx_dir_out <= 1'b0;
      end else if (ce_in) begin
         txd_out    <= tx_line_r & ~lcr_r[LCR_BRK_BIT];
         tx_dir_out <= md_ctl_r[MD_DIR_BIT] &
                       ((tx_st_r != URD_IDLE) ^ md_ctl_r[MD_INV_BIT]);
      end
   end
endmodule : urd_top

// ---- testbench/urd_top_asserts.sv ----
// Property checker bound to the serial port register datapath
`timescale 1ns/1ps
module urd_top_asserts (
   // Clock and control
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic        ce_in,
   // Register port and line
   input wire logic [6:0]  addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rd_data_out,
   input wire logic        rxd_in,
   input wire logic        txd_out,
   input wire logic        tx_dir_out
);
   logic fresh_r;
   // High from reset until the first register write
   always_ff @(posedge clk_in) fresh_r <= !rstn_in || (fresh_r && !wr_in);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   property p_rv(logic [6:0] a, logic [31:0] v);
      fresh_r && rd_in && addr_in == a |=> rd_data_out == v;
   endproperty
   a_status_reset: assert property (p_rv(7'h14, 32'h60)) else $error("status reset");
   a_ident_reset: assert property (p_rv(7'h08, 32'h01)) else $error("ident reset");
   a_frac_reset: assert property (p_rv(7'h28, 32'h10)) else $error("fraction reset");
   a_txen_reset: assert property (p_rv(7'h30, 32'h80)) else $error("tx enable reset");
   a_linectl_reset: assert property (p_rv(7'h0C, 32'h00)) else $error("line ctl reset");
   a_scratch_rw: assert property (wr_in && addr_in == 7'h1C ##1 rd_in && addr_in == 7'h1C
      |=> rd_data_out == {24'h0, $past(wr_data_in[7:0], 2)}) else $error("scratch");
   a_rx_upper_zero: assert property ($past(rd_in && addr_in == 7'h00) |-> rd_data_out[31:8] == 24'h0)
      else $error("upper bits");
   a_tx_idle_high: assert property ($past(!rstn_in) |-> txd_out && !tx_dir_out) else $error("idle");
   cover property (rd_in && addr_in == 7'h00);
   cover property (wr_in && addr_in == 7'h00);
   cover property ($fell(txd_out));
endmodule : urd_top_asserts
bind urd_top urd_top_asserts u_chk (.*);

// ---- testbench/urd_remote.sv ----
// Behavioural far-end serial transceiver
`timescale 1ns/1ps
module urd_remote #(
   parameter int BIT_CLKS = 16
) (
   // Clock and line
   input  wire logic clk_in,
   input  wire logic txd_in,
   output logic      rxd_out = 1'b1,
   // Last character heard and count
   output logic [7:0] got_out,
   output int         got_cnt_out = 0
);
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_out <= f[i];
         repeat (BIT_CLKS) @(posedge clk_in);
      end
   endtask : send
   always begin
      @(negedge txd_in);
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clk_in);
         got_out[i] = txd_in;
      end
      repeat (BIT_CLKS) @(posedge clk_in);
      if (txd_in) got_cnt_out++;
   end
endmodule : urd_remote

// ---- testbench/urd_top_tb.sv ----
// Self-checking bench for the serial port register datapath
`timescale 1ns/1ps
module urd_top_tb;
   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic [6:0]  addr_in = 7'h00;
   logic [31:0] wr_data_in = 32'h0;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic [31:0] rd_data_out;
   logic        rxd, txd, tx_dir;
   logic [7:0]  got;
   int          got_cnt, bad_count = 0, n_tests = 0;
   always #5 clk_in = ~clk_in;
   urd_top dut (.clk_in, .rstn_in, .ce_in(1'b1), .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
                .rxd_in(rxd), .txd_out(txd), .tx_dir_out(tx_dir));
   urd_remote far (.clk_in, .txd_in(txd), .rxd_out(rxd), .got_out(got), .got_cnt_out(got_cnt));
   task chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wr_data_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task rd(input logic [6:0] a, input logic [31:0] e);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk(rd_data_out, e);
      @(posedge clk_in);
   endtask : rd
   task tx_wait(input logic [7:0] b, input int n);
      for (int i = 0; i < 400 && got_cnt < n; i++) @(posedge clk_in);
      chk({24'h0, got}, {24'h0, b});
   endtask : tx_wait
   task t_reset;
      rd(7'h14, 32'h60);
      rd(7'h08, 32'h01);
      rd(7'h28, 32'h10);
      rd(7'h30, 32'h80);
      rd(7'h0C, 32'h00);
      rd(7'h04, 32'h00);
      rd(7'h20, 32'h00);
      rd(7'h50, 32'h00);
   endtask : t_reset
   task t_bank;
      wr(7'h0C, 32'h83);
      rd(7'h00, 32'h01);
      rd(7'h04, 32'h00);
      wr(7'h00, 32'h00);
      rd(7'h00, 32'h00);
      wr(7'h0C, 32'h03);
      wr(7'h04, 32'h307);
      rd(7'h04, 32'h307);
      wr(7'h1C, 32'h1234_5678);
      rd(7'h1C, 32'h78);
   endtask : t_bank
   task t_tx;
      wr(7'h00, 32'hA5);
      wr(7'h00, 32'h3C);
      tx_wait(8'hA5, 1);
      tx_wait(8'h3C, 2);
      wr(7'h30, 32'h00);
      wr(7'h00, 32'h5A);
      repeat (400) @(posedge clk_in);
      chk(got_cnt, 2);
      wr(7'h30, 32'h80);
      tx_wait(8'h5A, 3);
      wr(7'h4C, 32'h10);
      wr(7'h00, 32'h66);
      repeat (8) @(posedge clk_in);
      chk({31'h0, tx_dir}, 32'h1);
      tx_wait(8'h66, 4);
      repeat (20) @(posedge clk_in);
      chk({31'h0, tx_dir}, 32'h0);
   endtask : t_tx
   task t_rx;
      far.send(8'hC3);
      far.send(8'h81);
      repeat (20) @(posedge clk_in);
      rd(7'h14, 32'h61);
      rd(7'h08, 32'h04);
      wr(7'h08, 32'h41);
      rd(7'h08, 32'hC2);
      rd(7'h00, 32'hC3);
      rd(7'h00, 32'h81);
      wr(7'h0C, 32'h00);
      far.send(8'hFF);
      repeat (20) @(posedge clk_in);
      rd(7'h00, 32'h1F);
   endtask : t_rx
   task end_of_test;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      t_reset;
      t_bank;
      t_tx;
      t_rx;
      end_of_test;
   end
   initial begin
      #100us;
      bad_count++;
      end_of_test;
   end
endmodule : urd_top_tb
